// ===== src/scc_pin_drive.sv
// one sink output channel: gated enable and current decode
`timescale 1ns/1ps
`default_nettype none
module scc_pin_drive
	import scc_pkg::*;
#(
	parameter int STEP_MA = SCC_STEP0_MA
) (
	// clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                clk_en,
	// setting from the register bank
	scc_pin_if.dst                   set,
	// decoded drive
	output var  logic                sink_on,
	output var  logic [SCC_MA_W-1:0] sink_ma
);
	function automatic logic [SCC_MA_W-1:0] code_to_ma(input logic [4:0] c, input int step);
		code_to_ma = SCC_MA_W'(SCC_BASE_MA + step * int'(c));
	endfunction : code_to_ma

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sink_on <= 1'b0;
			sink_ma <= '0;
		end else if (clk_en) begin
			// off means floating pin and zero current
			sink_on <= set.enable;
			sink_ma <= set.enable ? code_to_ma(set.code, STEP_MA) : '0;
		end
	end
endmodule : scc_pin_drive
`default_nettype wire

// ===== src/scc_pin_if.sv
// interface carrying one pin's decoded sink setting
`timescale 1ns/1ps
`default_nettype none
interface scc_pin_if;
	logic                  enable;
	logic [4:0]            code;
	modport src (output enable, output code);
	modport dst (input enable, input code);
endinterface : scc_pin_if
`default_nettype wire

// ===== src/scc_pkg.sv
// package of constants and types for the sink current control register bank
package scc_pkg;
	// register byte offsets on the AHB-Lite bus
	localparam logic [7:0] SCC_OFS_ENABLE = 8'h00;
	localparam logic [7:0] SCC_OFS_CODE0  = 8'h04;
	localparam logic [7:0] SCC_OFS_CODE1  = 8'h08;
	localparam logic [7:0] SCC_OFS_STATUS = 8'h0C;
	// field positions in the enable register, and the code field width
	localparam int SCC_BIT_MASTER = 7;
	localparam int SCC_BIT_PIN1   = 1;
	localparam int SCC_BIT_PIN0   = 0;
	localparam int SCC_CODE_W     = 5;
	// reset values
	localparam logic [7:0] SCC_RST_ENABLE = 8'h00;
	localparam logic [SCC_CODE_W-1:0] SCC_RST_CODE = 5'h00;
	// current transfer: base plus step per code, in milliamps
	localparam int SCC_BASE_MA   = 50;
	localparam int SCC_STEP0_MA  = 10;
	localparam int SCC_STEP1_MA  = 5;
	localparam int SCC_MA_W      = 9;
	// ahb encodings
	localparam logic [1:0] SCC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] SCC_HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] SCC_HSIZE_WORD    = 3'h2;
endpackage : scc_pkg

// ===== src/scc_regs.sv
// sink current control register bank with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module scc_regs
	import scc_pkg::*;
(
	// clock, reset and enable
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                clk_en,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output var  logic [31:0]         hrdata,
	output var  logic                hreadyout,
	output var  logic                hresp,
	// sink pin drive
	output var  logic                sink_out_pin_a_en,
	output var  logic [SCC_MA_W-1:0] sink_out_pin_a_ma,
	output var  logic                sink_out_pin_b_en,
	output var  logic [SCC_MA_W-1:0] sink_out_pin_b_ma
);
	logic                  sink_master_enable_r;
	logic                  sink_pin1_enable_r;
	logic                  sink_pin0_enable_r;
	logic [SCC_CODE_W-1:0] sink_pin0_current_code_r;
	logic [SCC_CODE_W-1:0] sink_pin1_current_code_r;
	logic                  sink_master_enable_nxt;
	logic                  sink_pin1_enable_nxt;
	logic                  sink_pin0_enable_nxt;
	logic [SCC_CODE_W-1:0] sink_pin0_current_code_nxt;
	logic [SCC_CODE_W-1:0] sink_pin1_current_code_nxt;
	logic                  wr_enable_hit;
	logic                  wr_code0_hit;
	logic                  wr_code1_hit;
	logic                  wr_pend_r;
	logic [7:0]            wr_addr_r;
	logic                  rd_go;
	logic                  wr_go;
	logic [31:0]           rd_nxt;

	scc_pin_if pin_a ();
	scc_pin_if pin_b ();

	function automatic logic [31:0] read_mux(input logic [7:0] a, input logic m,
			input logic p1, input logic p0, input logic [4:0] c0, input logic [4:0] c1,
			input logic oa, input logic ob);
		read_mux = 32'h0000_0000;
		case (a)
			SCC_OFS_ENABLE: begin
				read_mux[SCC_BIT_MASTER] = m;
				read_mux[SCC_BIT_PIN1] = p1;
				read_mux[SCC_BIT_PIN0] = p0;
			end
			SCC_OFS_CODE0: read_mux[SCC_CODE_W-1:0] = c0;
			SCC_OFS_CODE1: read_mux[SCC_CODE_W-1:0] = c1;
			SCC_OFS_STATUS: begin
				read_mux[SCC_BIT_PIN1] = ob;
				read_mux[SCC_BIT_PIN0] = oa;
			end
			default: read_mux = 32'h0000_0000;
		endcase
	endfunction : read_mux

	// selected word transfer in its address phase, either direction
	function automatic logic word_xfer(input logic sel, input logic rdy, input logic [1:0] tr,
			input logic [2:0] sz);
		word_xfer = sel && rdy && tr[1] && (sz == SCC_HSIZE_WORD);
	endfunction : word_xfer

	// pending data phase aimed at one register
	function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = pend && (a == ofs);
	endfunction : wr_hit

	// a word transfer in the address phase
	assign rd_go = word_xfer(hsel, hready, htrans, hsize) && !hwrite;
	assign wr_go = word_xfer(hsel, hready, htrans, hsize) && hwrite;

	// writes land at the end of their data phase; clk_en low holds them off
	assign wr_enable_hit = clk_en && wr_hit(wr_pend_r, wr_addr_r, SCC_OFS_ENABLE);
	assign wr_code0_hit  = clk_en && wr_hit(wr_pend_r, wr_addr_r, SCC_OFS_CODE0);
	assign wr_code1_hit  = clk_en && wr_hit(wr_pend_r, wr_addr_r, SCC_OFS_CODE1);
	assign rd_nxt = read_mux(haddr[7:0], sink_master_enable_r, sink_pin1_enable_r,
		sink_pin0_enable_r, sink_pin0_current_code_r, sink_pin1_current_code_r,
		sink_out_pin_a_en, sink_out_pin_b_en);

	// zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else if (clk_en) begin
			if (hready) begin
				wr_pend_r <= wr_go;
				wr_addr_r <= haddr[7:0];
			end
		end
	end

	// read data registered for its data phase, zero otherwise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en) begin
			hrdata <= rd_go ? rd_nxt : 32'h0000_0000;
		end
	end

	// next register values; unimplemented enable bits are simply never taken
	always_comb begin
		sink_master_enable_nxt     = sink_master_enable_r;
		sink_pin1_enable_nxt       = sink_pin1_enable_r;
		sink_pin0_enable_nxt       = sink_pin0_enable_r;
		sink_pin0_current_code_nxt = sink_pin0_current_code_r;
		sink_pin1_current_code_nxt = sink_pin1_current_code_r;
		if (wr_enable_hit) begin
			sink_master_enable_nxt = hwdata[SCC_BIT_MASTER];
			sink_pin1_enable_nxt   = hwdata[SCC_BIT_PIN1];
			sink_pin0_enable_nxt   = hwdata[SCC_BIT_PIN0];
		end
		if (wr_code0_hit) begin
			sink_pin0_current_code_nxt = hwdata[SCC_CODE_W-1:0];
		end
		if (wr_code1_hit) begin
			sink_pin1_current_code_nxt = hwdata[SCC_CODE_W-1:0];
		end
	end

	// master enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sink_master_enable_r <= SCC_RST_ENABLE[SCC_BIT_MASTER];
		end else if (clk_en) begin
			sink_master_enable_r <= sink_master_enable_nxt;
		end
	end

	// pin b enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sink_pin1_enable_r <= SCC_RST_ENABLE[SCC_BIT_PIN1];
		end else if (clk_en) begin
			sink_pin1_enable_r <= sink_pin1_enable_nxt;
		end
	end

	// pin a enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sink_pin0_enable_r <= SCC_RST_ENABLE[SCC_BIT_PIN0];
		end else if (clk_en) begin
			sink_pin0_enable_r <= sink_pin0_enable_nxt;
		end
	end

	// pin a current code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sink_pin0_current_code_r <= SCC_RST_CODE;
		end else if (clk_en) begin
			sink_pin0_current_code_r <= sink_pin0_current_code_nxt;
		end
	end

	// pin b current code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sink_pin1_current_code_r <= SCC_RST_CODE;
		end else if (clk_en) begin
			sink_pin1_current_code_r <= sink_pin1_current_code_nxt;
		end
	end

	// master enable gates both pins
	assign pin_a.enable = sink_master_enable_r && sink_pin0_enable_r;
	assign pin_a.code   = sink_pin0_current_code_r;
	assign pin_b.enable = sink_master_enable_r && sink_pin1_enable_r;
	assign pin_b.code   = sink_pin1_current_code_r;

	scc_pin_drive #(.STEP_MA(SCC_STEP0_MA)) u_pin_a (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.set     (pin_a),
		.sink_on (sink_out_pin_a_en),
		.sink_ma (sink_out_pin_a_ma)
	);

	scc_pin_drive #(.STEP_MA(SCC_STEP1_MA)) u_pin_b (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.set     (pin_b),
		.sink_on (sink_out_pin_b_en),
		.sink_ma (sink_out_pin_b_ma)
	);
endmodule : scc_regs
`default_nettype wire

// ===== verification/scc_regs_asserts.sv
// assertion checker for the sink current register bank
`timescale 1ns/1ps
`default_nettype none
module scc_regs_asserts
	import scc_pkg::*;
(
	// clock, reset and enable
	input wire logic                hclk,
	input wire logic                hresetn,
	input wire logic                clk_en,
	// bus
	input wire logic                hsel,
	input wire logic                hwrite,
	input wire logic                hready,
	input wire logic                hreadyout,
	input wire logic                hresp,
	input wire logic [31:0]         haddr,
	input wire logic [31:0]         hwdata,
	input wire logic [31:0]         hrdata,
	input wire logic [1:0]          htrans,
	input wire logic [2:0]          hsize,
	// pin drive
	input wire logic                sink_out_pin_a_en,
	input wire logic                sink_out_pin_b_en,
	input wire logic [SCC_MA_W-1:0] sink_out_pin_a_ma,
	input wire logic [SCC_MA_W-1:0] sink_out_pin_b_ma
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// one accepted word transfer, ending at its data phase edge
	sequence taken(logic [7:0] ofs, logic w);
		clk_en && hsel && hready && htrans[1] && hwrite == w && hsize == SCC_HSIZE_WORD
			&& haddr[7:0] == ofs ##1 clk_en;
	endsequence
	sequence wr_en(int b);
		taken(SCC_OFS_ENABLE, 1'h1) ##0 !hwdata[b] ##1 clk_en;
	endsequence
	a_reset_off: assert property ($rose(hresetn) |-> !sink_out_pin_a_en && !sink_out_pin_b_en)
		else $error("pins on after reset");
	a_master_off: assert property (wr_en(7) |-> ##1 !sink_out_pin_a_en && !sink_out_pin_b_en)
		else $error("master clear left a pin on");
	a_pin_a_gate: assert property (wr_en(0) |-> ##1 !sink_out_pin_a_en)
		else $error("pin a gate");
	a_pin_b_gate: assert property (wr_en(1) |-> ##1 !sink_out_pin_b_en)
		else $error("pin b gate");
	a_pin_a_step: assert property (sink_out_pin_a_en |-> sink_out_pin_a_ma >= 50
		&& sink_out_pin_a_ma <= 360 && (sink_out_pin_a_ma - 50) % 10 == 0) else $error("pin a current");
	a_pin_b_step: assert property (sink_out_pin_b_en |-> sink_out_pin_b_ma >= 50
		&& sink_out_pin_b_ma <= 205 && (sink_out_pin_b_ma - 50) % 5 == 0) else $error("pin b current");
	a_float_zero: assert property ((!sink_out_pin_a_en |-> sink_out_pin_a_ma == 9'h0)
		and (!sink_out_pin_b_en |-> sink_out_pin_b_ma == 9'h0)) else $error("floating pin sinks");
	a_enable_rsvd: assert property (taken(SCC_OFS_ENABLE, 1'h0) |-> hrdata[6:2] == 5'h0)
		else $error("reserved enable bits set");
	a_bus_okay: assert property (hreadyout && !hresp) // no wait states, always okay
		else $error("bus answer not okay or waiting");
endmodule : scc_regs_asserts
bind scc_regs scc_regs_asserts scc_regs_asserts_inst (.hclk, .hresetn, .clk_en, .hsel, .hwrite,
	.hready, .hreadyout, .hresp, .haddr, .hwdata, .hrdata, .htrans, .hsize, .sink_out_pin_a_en,
	.sink_out_pin_b_en, .sink_out_pin_a_ma, .sink_out_pin_b_ma);
`default_nettype wire

// ===== verification/test_sink_current_control_regs.sv
// self-checking testbench for the sink current register bank
`timescale 1ns/1ps
`default_nettype none
module test_sink_current_control_regs import scc_pkg::*;;
	logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, hready, hresp, a_en, b_en;
	logic clk_en = 1'h1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [SCC_MA_W-1:0] a_ma, b_ma;
	int bad_count = 0, checks_done = 0;
	always #4 hclk = ~hclk;
	scc_regs scc_regs_inst (.hclk, .hresetn, .clk_en, .hsel(1'h1), .haddr, .htrans, .hwrite,
		.hsize(SCC_HSIZE_WORD), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
		.sink_out_pin_a_en(a_en), .sink_out_pin_a_ma(a_ma), .sink_out_pin_b_en(b_en),
		.sink_out_pin_b_ma(b_ma));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= SCC_HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		rd = hrdata;
	endtask : xfer
	task automatic t_reset;
		for (int i = 0; i < 3; i++) begin
			xfer(1'h0, 8'(4 * i), 32'h0);
			chk("reset reg", 32'h0, rd);
		end
		chk("reset pins", 32'h0, 32'({a_en, a_ma, b_en, b_ma}));
	endtask : t_reset
	task automatic t_fields;
		logic [7:0] adr[4] = '{SCC_OFS_ENABLE, SCC_OFS_CODE0, SCC_OFS_CODE1, 8'h10};
		logic [31:0] ev[4] = '{32'h83, 32'h1F, 32'h1F, 32'h0};
		for (int i = 0; i < 4; i++) begin
			xfer(1'h1, adr[i], 32'hFFFF_FFFF);
			xfer(1'h0, adr[i], 32'h0);
			chk("readback", ev[i], rd);
		end
	endtask : t_fields
	task automatic t_pins;
		logic [7:0] en[5] = '{8'h81, 8'h82, 8'h03, 8'h83, 8'h80};
		logic [4:0] c[5] = '{5'h00, 5'h1F, 5'h1F, 5'h0A, 5'h05};
		logic [4:0] d;
		logic oa, ob;
		for (int i = 0; i < 5; i++) begin
			d = ~c[i];
			xfer(1'h1, SCC_OFS_CODE0, {27'h0, c[i]});
			xfer(1'h1, SCC_OFS_CODE1, {27'h0, d});
			xfer(1'h1, SCC_OFS_ENABLE, {24'h0, en[i]});
			repeat (2) @(posedge hclk);
			oa = en[i][7] & en[i][0];
			ob = en[i][7] & en[i][1];
			chk("pin a ma", oa ? 32'(SCC_BASE_MA + SCC_STEP0_MA * c[i]) : 32'h0, 32'(a_ma));
			chk("pin b ma", ob ? 32'(SCC_BASE_MA + SCC_STEP1_MA * d) : 32'h0, 32'(b_ma));
			chk("pin on", {30'h0, oa, ob}, {30'h0, a_en, b_en});
			xfer(1'h0, SCC_OFS_STATUS, 32'h0);
			chk("status", {30'h0, ob, oa}, rd);
		end
	endtask : t_pins
	task automatic t_freeze;
		xfer(1'h1, SCC_OFS_ENABLE, 32'h83);
		repeat (2) @(posedge hclk);
		clk_en <= 1'h0;
		xfer(1'h1, SCC_OFS_ENABLE, 32'h0);
		clk_en <= 1'h1;
		repeat (2) @(posedge hclk);
		chk("frozen pins", 32'h3, {30'h0, a_en, b_en});
		xfer(1'h0, SCC_OFS_ENABLE, 32'h0);
		chk("frozen write", 32'h83, rd);
	endtask : t_freeze
	task automatic t_rerun;
		@(posedge hclk);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		chk("pins in reset", 32'h0, 32'({a_en, a_ma, b_en, b_ma}));
		hresetn <= 1'h1;
		t_reset();
	endtask : t_rerun
	task automatic conclude;
		if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		t_reset();
		t_fields();
		t_pins();
		t_freeze();
		t_rerun();
		conclude();
	end
	initial begin
		#20000;
		bad_count++;
		conclude();
	end
endmodule : test_sink_current_control_regs
`default_nettype wire
